// ==== verif/sih_contacts.sv ====
// Model of the switch contacts that close each control terminal to the digital common.
`timescale 1ns/1ps
`default_nettype none

module sih_contacts (
    input  wire logic       pclk,    // Clock that times the contact bounce.
    input  wire logic [4:0] closed,  // Requested contacts, 1 means shorted to common.
    input  wire logic [4:0] glitch,  // Commanded brief disturbance on each terminal.
    output logic      [4:0] pins     // Terminal levels seen by the handler.
);
    logic [4:0] settled_ff = 5'h00;  // Level the contacts settle to.
    logic [4:0] level_ff   = 5'h00;  // Level including bounce.
    logic [4:0] chg_ff     = 5'h00;  // Contacts that moved last.
    logic [1:0] bounce_ff  = 2'h0;   // Bounce cycles still to come.

    // A moving contact chatters for a few cycles before it settles, as real contacts do.
    always @(posedge pclk) begin
        if (closed != settled_ff) begin
            settled_ff <= closed;
            level_ff   <= closed;
            chg_ff     <= closed ^ settled_ff;
            bounce_ff  <= 2'h3;
        end else if (bounce_ff != 2'h0) begin
            bounce_ff <= bounce_ff - 2'h1;
            level_ff  <= (bounce_ff == 2'h1) ? settled_ff : level_ff ^ chg_ff;
        end
    end

    // The clear contact is only moved on request; one table case closes it without alarm or keep to shut the base off.
    assign pins = level_ff ^ glitch;
endmodule : sih_contacts

`default_nettype wire

// ==== verif/sih_tb_top.sv ====
// Self-checking testbench of the servo input signal handler.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module sih_tb_top;
    localparam int SC = 4;                // Shortened filter sample period.
    localparam int SETTLE = 4 * SC + 9;   // Filter, output and bounce latency bound.
    localparam logic [31:0] EN_EV = 32'((1 << sih_pkg::EV_EN) | (1 << sih_pkg::EV_BASE));

    // One case: configuration and pins beside {base, ccw, cw, lock} that they give.
    typedef struct packed {
        logic [2:0] frc;
        logic       keep;
        logic [1:0] asg;
        logic [4:0] pins;
        logic       alarm;
        logic [3:0] exp;
    } sih_row_type;

    // Pins are {aux, rev, fwd, clr, en}.
    sih_row_type rows [12] = '{
        '{3'h0, 1'h0, 2'h0, 5'h0d, 1'h0, 4'he}, '{3'h0, 1'h0, 2'h0, 5'h0c, 1'h0, 4'h6},
        '{3'h1, 1'h0, 2'h0, 5'h0c, 1'h0, 4'he}, '{3'h0, 1'h0, 2'h0, 5'h0f, 1'h0, 4'h6},
        '{3'h0, 1'h1, 2'h0, 5'h0f, 1'h0, 4'he}, '{3'h0, 1'h0, 2'h0, 5'h0f, 1'h1, 4'he},
        '{3'h0, 1'h0, 2'h0, 5'h09, 1'h0, 4'hb}, '{3'h0, 1'h0, 2'h0, 5'h05, 1'h0, 4'hd},
        '{3'h6, 1'h0, 2'h0, 5'h01, 1'h0, 4'he}, '{3'h0, 1'h0, 2'h0, 5'h1d, 1'h0, 4'he},
        '{3'h0, 1'h0, 2'h1, 5'h1d, 1'h0, 4'h6}, '{3'h0, 1'h0, 2'h2, 5'h1d, 1'h0, 4'he}};
    logic [7:0]  rst_ofs [4] = '{sih_pkg::OFS_FORCE, sih_pkg::OFS_CLRCFG,
                                 sih_pkg::OFS_ASSIGN, sih_pkg::OFS_IMASK};
    logic [31:0] rst_val [4] = '{32'(sih_pkg::FORCE_RST), 32'(sih_pkg::CLRCFG_RST),
                                 32'(sih_pkg::ASSIGN_RST), 32'(sih_pkg::IMASK_RST)};

    logic        pclk = 1'h0;   // System clock.
    logic        presetn;       // Reset, active low.
    logic        psel;          // APB select.
    logic        penable;       // APB enable.
    logic        pwrite;        // APB direction.
    logic [7:0]  paddr;         // APB address.
    logic [31:0] pwdata;        // APB write data.
    logic [31:0] prdata;        // APB read data.
    logic        pready;        // APB ready.
    logic        pslverr;       // APB error.
    logic [4:0]  closed;        // Requested contacts.
    logic [4:0]  glitch;        // Commanded disturbance.
    logic [4:0]  pins;          // Terminal levels.
    logic        alarm_active;  // Alarm state.
    logic        base_enable;   // Base circuit on.
    logic        ccw_allow;     // CCW travel allowed.
    logic        cw_allow;      // CW travel allowed.
    logic        servo_lock;    // Servo lock stop.
    logic        irq;           // Interrupt.
    logic [31:0] rd;            // Last read data.
    logic        er;            // Last error response.
    int          failures = 0;  // Mismatches.
    int          num_checks = 0;  // Comparisons made.

    // The clock toggles every half period of 2 ns.
    always #2 pclk = ~pclk;

    sih_contacts u_contacts (.pclk(pclk), .closed(closed), .glitch(glitch), .pins(pins));

    sih_top #(.SAMPLE_CYCLES(SC)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .drive_enable_input(pins[sih_pkg::IN_EN]),
        .alarm_clear_input(pins[sih_pkg::IN_CLR]), .forward_limit_input(pins[sih_pkg::IN_FWD]),
        .reverse_limit_input(pins[sih_pkg::IN_REV]), .aux_input(pins[sih_pkg::IN_AUX]),
        .alarm_active(alarm_active), .base_enable(base_enable), .ccw_allow(ccw_allow),
        .cw_allow(cw_allow), .servo_lock(servo_lock), .irq(irq));

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge; the answer waits under a bound.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            failures++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // Waits the longest acceptance time of a pin change.
    task automatic settle();
        repeat (SETTLE) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
        pwdata = 32'h0000_0000; closed = 5'h00; glitch = 5'h00; alarm_active = 1'h0;
        repeat (5) @(posedge pclk);
        `CHK({base_enable, ccw_allow, cw_allow, servo_lock, irq}, 5'h00)
        presetn <= 1'h1;
        @(posedge pclk);
        // Reset values, narrow fields and an unmapped address.
        foreach (rst_ofs[i]) begin
            apb(1'h0, rst_ofs[i], 32'h0000_0000);
            `CHK(rd, rst_val[i])
        end
        apb(1'h1, sih_pkg::OFS_FORCE, 32'hffff_ffff);
        apb(1'h0, sih_pkg::OFS_FORCE, 32'h0000_0000);
        `CHK(rd, 32'h0000_0007)
        apb(1'h1, 8'h18, 32'hffff_ffff);
        `CHK(er, 1'h1)
        apb(1'h0, 8'h18, 32'h0000_0000);
        `CHK({er, rd}, {1'h1, 32'h0000_0000})
        // Table of ordinary cases.
        foreach (rows[i]) begin
            apb(1'h1, sih_pkg::OFS_FORCE, 32'(rows[i].frc));
            apb(1'h1, sih_pkg::OFS_CLRCFG, 32'(rows[i].keep));
            apb(1'h1, sih_pkg::OFS_ASSIGN, 32'(rows[i].asg));
            closed <= rows[i].pins;
            alarm_active <= rows[i].alarm;
            settle();
            `CHK(base_enable, rows[i].exp[3])
            `CHK({ccw_allow, cw_allow, servo_lock}, rows[i].exp[2:0])
            apb(1'h0, sih_pkg::OFS_STATE, 32'h0000_0000);
            `CHK(rd[7:0], {rows[i].alarm, rows[i].exp[0], rows[i].exp[3], rows[i].pins})
        end
        // A two-cycle dip on the enable terminal is no change of input and logs no event.
        apb(1'h0, sih_pkg::OFS_ISTAT, 32'h0000_0000);
        glitch <= 5'h01;
        repeat (2) @(posedge pclk);
        glitch <= 5'h00;
        settle();
        `CHK(base_enable, 1'h1)
        // Interrupt raised, cleared by read, then masked.
        apb(1'h0, sih_pkg::OFS_ISTAT, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        apb(1'h1, sih_pkg::OFS_IMASK, 32'h0000_0001);
        closed <= 5'h1c;
        settle();
        `CHK({irq, base_enable}, 2'h2)
        apb(1'h0, sih_pkg::OFS_ISTAT, 32'h0000_0000);
        `CHK(rd, EN_EV)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'h0)
        apb(1'h1, sih_pkg::OFS_IMASK, 32'h0000_0000);
        closed <= 5'h1d;
        settle();
        `CHK({irq, base_enable}, 2'h1)
        apb(1'h0, sih_pkg::OFS_ISTAT, 32'h0000_0000);
        `CHK(rd, EN_EV)
        // Reset in mid-run drops the base and clears the configuration.
        apb(1'h1, sih_pkg::OFS_FORCE, 32'h0000_0007);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        `CHK({base_enable, ccw_allow, cw_allow, servo_lock, irq}, 5'h00)
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        `CHK(servo_lock, 1'h1)
        settle();
        `CHK({base_enable, ccw_allow, cw_allow, servo_lock}, 4'he)
        test_done();
    end
endmodule : sih_tb_top

`default_nettype wire

// ==== verilog/sih_filt_if.sv ====
// Interface between the handler core and its input filter.
`timescale 1ns/1ps
`default_nettype none

interface sih_filt_if;
    logic [sih_pkg::IN_WIDTH-1:0] raw;     // Terminal levels from the pins.
    logic [sih_pkg::IN_WIDTH-1:0] clean;   // Accepted levels.
    logic [sih_pkg::IN_WIDTH-1:0] changed; // One-cycle pulse on an accepted change.

    modport filt (input raw, output clean, output changed);  // Filter side.
    modport core (output raw, input clean, input changed);   // Core side.
endinterface : sih_filt_if

`default_nettype wire

// ==== verilog/sih_in_filter.sv ====
// Synchroniser and sampling filter for the control terminals.
`timescale 1ns/1ps
`default_nettype none

module sih_in_filter #(
    parameter int SAMPLE_CYCLES = sih_pkg::SAMPLE_CYCLES   // Sample period in cycles.
) (
    input  wire logic  pclk,     // System clock.
    input  wire logic  presetn,  // Asynchronous reset, active low.
    sih_filt_if.filt   fif       // Raw levels in, accepted levels out.
);

    localparam int W = sih_pkg::IN_WIDTH;   // Terminal count.

    logic [W-1:0] meta_ff;        // First synchroniser stage.
    logic [W-1:0] sync_ff;        // Second synchroniser stage.
    logic [W-1:0] clean_ff;       // Accepted levels.
    logic [W-1:0] changed_ff;     // Change pulses.
    logic [W-1:0][1:0] cnt_ff;    // Equal-sample counters per terminal.
    logic [31:0]  div_ff;         // Sample period divider.
    logic         tick_ff;        // One-cycle sample enable.

    assign fif.clean   = clean_ff;
    assign fif.changed = changed_ff;

    // Two flip-flops bring the pin levels into the clock domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= fif.raw;
            sync_ff <= meta_ff;
        end
    end

    // The divider makes the sample enable.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(SAMPLE_CYCLES - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // A new level is accepted after it held for the set number of samples.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff     <= '0;
            clean_ff   <= '0;
            changed_ff <= '0;
        end else begin
            changed_ff <= '0;
            for (int i = 0; i < W; i++) begin
                if (tick_ff) begin
                    if (sync_ff[i] == clean_ff[i]) begin
                        cnt_ff[i] <= 2'h0;
                    end else if (cnt_ff[i] == 2'(sih_pkg::FILT_SAMPLES - 1)) begin
                        cnt_ff[i]     <= 2'h0;
                        clean_ff[i]   <= sync_ff[i];   // RULE1
                        changed_ff[i] <= 1'b1;
                    end else begin
                        cnt_ff[i] <= cnt_ff[i] + 2'h1;
                    end
                end
            end
        end
    end

    // Helper: cycles that a synchronised level has differed from the accepted one.
    logic [W-1:0][31:0] lag_ff;   // Lag counters, read only by the assertion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag_ff <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                lag_ff[i] <= (sync_ff[i] == clean_ff[i]) ? 32'h0000_0000
                                                         : lag_ff[i] + 32'h0000_0001;
            end
        end
    end

    // A held change on the enable or forward limit terminal is accepted inside the acceptance bound.
    accept_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        lag_ff[0] < 32'(sih_pkg::ACCEPT_CYCLES) && lag_ff[2] < 32'(sih_pkg::ACCEPT_CYCLES))
        else $error("Input change not accepted within the bound.");

endmodule : sih_in_filter

`default_nettype wire

// ==== verilog/sih_pkg.sv ====
// Package with the constants shared by the servo input signal handler.
`default_nettype none

package sih_pkg;

    // Input vector bit positions, level 1 means the terminal is shorted to common.
    localparam int IN_EN      = 0;      // Drive enable terminal.
    localparam int IN_CLR     = 1;      // Alarm clear terminal.
    localparam int IN_FWD     = 2;      // Forward limit terminal.
    localparam int IN_REV     = 3;      // Reverse limit terminal.
    localparam int IN_AUX     = 4;      // Optional terminal, function set by software.
    localparam int IN_WIDTH   = 5;      // Number of filtered terminals.

    // Timing: acceptance bound and filter sampling.
    localparam int CLK_MHZ        = 250;                       // Clock rate in MHz.
    localparam int ACCEPT_MS      = 10;                        // Acceptance bound in ms.
    localparam int ACCEPT_CYCLES  = ACCEPT_MS * 1000 * CLK_MHZ; // Longest time, cycles.
    localparam int SAMPLE_US      = 1000;                      // Filter sample period in us.
    localparam int SAMPLE_CYCLES  = SAMPLE_US * CLK_MHZ;       // Sample period, cycles.
    localparam int FILT_SAMPLES   = 3;                         // Equal samples to accept.

    // Register byte offsets.
    localparam logic [7:0] OFS_FORCE  = 8'h00; // Forced-on inputs.
    localparam logic [7:0] OFS_CLRCFG = 8'h04; // Alarm clear behaviour.
    localparam logic [7:0] OFS_ASSIGN = 8'h08; // Optional terminal assignment.
    localparam logic [7:0] OFS_STATE  = 8'h0C; // Live state, read only.
    localparam logic [7:0] OFS_ISTAT  = 8'h10; // Sticky events, cleared on read.
    localparam logic [7:0] OFS_IMASK  = 8'h14; // Event mask.

    // Field positions and reset values.
    localparam int FRC_EN   = 0;              // Force drive enable on.
    localparam int FRC_FWD  = 1;              // Force forward limit on.
    localparam int FRC_REV  = 2;              // Force reverse limit on.
    localparam int CFG_KEEP = 0;              // Keep base on for alarm clear.
    localparam logic [2:0] FORCE_RST  = 3'h0; // Nothing forced after reset.
    localparam logic [0:0] CLRCFG_RST = 1'h0; // Alarm clear shuts the base off.
    localparam logic [1:0] ASSIGN_RST = 2'h0; // Optional terminal unassigned.
    localparam logic [4:0] IMASK_RST  = 5'h00; // All events masked.

    // Function codes for the optional terminal.
    typedef enum logic [1:0] {
        SIH_AUX_NONE = 2'h0,   // No function.
        SIH_AUX_CLR  = 2'h1    // Second alarm clear source.
    } sih_aux_type;

    // Event bit positions.
    localparam int EV_EN   = 0;   // Drive enable changed.
    localparam int EV_CLR  = 1;   // Alarm clear changed.
    localparam int EV_FWD  = 2;   // Forward limit reached.
    localparam int EV_REV  = 3;   // Reverse limit reached.
    localparam int EV_BASE = 4;   // Base circuit changed.
    localparam int EV_WIDTH = 5;  // Number of events.

endpackage : sih_pkg

`default_nettype wire

// ==== verilog/sih_top.sv ====
// Servo input signal handler: enable, alarm clear and limit inputs with APB registers.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE1] Accept any input change within 10 ms.
// [RULE2] Enable input shorted turns base circuit on.
// [RULE3] Enable input open turns base circuit off.
// [RULE4] Force bit keeps enable asserted regardless.
// [RULE5] Alarm clear without alarm shuts base off.
// [RULE6] Keep bit holds base on during clear.
// [RULE7] Controller must not stop motor by clear.
// [RULE8] Limit open reads 0, stops with lock.
// [RULE9] Force bits keep each limit shorted internally.
// [RULE10] Optional function works only once assigned.
// [RULE11] Forward limit blocks CCW, reverse blocks CW.
module sih_top #(
    parameter int SAMPLE_CYCLES = sih_pkg::SAMPLE_CYCLES    // Filter sample period.
) (
    input  wire logic        pclk,                 // System clock, 250 MHz.
    input  wire logic        presetn,              // Asynchronous reset, active low.
    input  wire logic        psel,                 // APB select.
    input  wire logic        penable,              // APB enable.
    input  wire logic        pwrite,               // APB direction, 1 writes.
    input  wire logic [7:0]  paddr,                // APB byte address.
    input  wire logic [31:0] pwdata,               // APB write data.
    output logic      [31:0] prdata,               // APB read data.
    output logic             pready,               // APB ready.
    output logic             pslverr,              // APB error on unmapped address.
    input  wire logic        drive_enable_input,   // 1 while shorted to common.
    input  wire logic        alarm_clear_input,    // 1 while shorted to common.
    input  wire logic        forward_limit_input,  // 1 while shorted to common.
    input  wire logic        reverse_limit_input,  // 1 while shorted to common.
    input  wire logic        aux_input,            // Optional terminal, 1 when shorted.
    input  wire logic        alarm_active,         // Alarm state from the alarm logic.
    output logic             base_enable,          // Power-stage base circuit on.
    output logic             ccw_allow,            // Counter-clockwise travel allowed.
    output logic             cw_allow,             // Clockwise travel allowed.
    output logic             servo_lock,           // Abrupt stop with servo lock.
    output logic             irq                   // Level interrupt.
);

    sih_filt_if fif ();   // Filter connection.

    logic [2:0]                    force_ff;    // Forced-on inputs.
    logic [0:0]                    clrcfg_ff;   // Keep base on for alarm clear.
    sih_pkg::sih_aux_type          assign_ff;   // Optional terminal function.
    logic [sih_pkg::EV_WIDTH-1:0]  istat_ff;    // Sticky events.
    logic [sih_pkg::EV_WIDTH-1:0]  imask_ff;    // Event mask.
    logic [31:0]                   prdata_ff;   // Read data.
    logic                          pready_ff;   // Ready.
    logic                          pslverr_ff;  // Error.
    logic                          base_ff;     // Base circuit state.
    logic                          ccw_ff;      // CCW allowed.
    logic                          cw_ff;       // CW allowed.
    logic                          lock_ff;     // Servo lock.
    logic                          irq_ff;      // Interrupt.

    logic eff_en;     // Drive enable after forcing.
    logic eff_clr;    // Alarm clear from any assigned terminal.
    logic eff_fwd;    // Forward limit after forcing.
    logic eff_rev;    // Reverse limit after forcing.
    logic nxt_base;   // Next base state.
    logic setup;      // APB setup phase.
    logic wr_done;    // Write completes this cycle.
    logic rd_done;    // Read completes this cycle.
    logic [sih_pkg::EV_WIDTH-1:0] events;   // Event pulses.

    assign fif.raw = {aux_input, reverse_limit_input, forward_limit_input,
                      alarm_clear_input, drive_enable_input};

    sih_in_filter #(
        .SAMPLE_CYCLES (SAMPLE_CYCLES)
    ) u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .fif     (fif.filt)
    );

    // Register word decode for the error logic; reads use their own case.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == sih_pkg::OFS_FORCE)  || (a == sih_pkg::OFS_CLRCFG) ||
                 (a == sih_pkg::OFS_ASSIGN) || (a == sih_pkg::OFS_STATE)  ||
                 (a == sih_pkg::OFS_ISTAT)  || (a == sih_pkg::OFS_IMASK);
    endfunction

    // Forced and assigned inputs form the effective control levels.
    always_comb begin
        eff_en  = fif.clean[sih_pkg::IN_EN] | force_ff[sih_pkg::FRC_EN];      // RULE4
        eff_clr = fif.clean[sih_pkg::IN_CLR] |
                  (fif.clean[sih_pkg::IN_AUX] && assign_ff == sih_pkg::SIH_AUX_CLR); // RULE10
        eff_fwd = fif.clean[sih_pkg::IN_FWD] | force_ff[sih_pkg::FRC_FWD];    // RULE9
        eff_rev = fif.clean[sih_pkg::IN_REV] | force_ff[sih_pkg::FRC_REV];    // RULE9
        // Clearing with no alarm shuts the base off unless configured to keep it.
        nxt_base = eff_en &&                                                  // RULE2
                   !(eff_clr && !alarm_active && !clrcfg_ff[sih_pkg::CFG_KEEP]); // RULE5
    end

    // The base circuit follows the effective enable and clear levels.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= 1'b0;
        end else begin
            base_ff <= nxt_base;   // RULE3
        end
    end

    // Limit levels gate each travel direction; a missing limit locks the servo.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ccw_ff  <= 1'b0;
            cw_ff   <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            ccw_ff  <= eff_fwd;              // RULE11
            cw_ff   <= eff_rev;              // RULE11
            lock_ff <= !eff_fwd || !eff_rev; // RULE8
        end
    end

    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pready_ff && pwrite;
    assign rd_done = psel && penable && pready_ff && !pwrite;

    // APB answers one cycle after setup; read data is latched in setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped(paddr);
            if (setup && !pwrite) begin
                unique case (paddr)
                    sih_pkg::OFS_FORCE:  prdata_ff <= {29'h0, force_ff};
                    sih_pkg::OFS_CLRCFG: prdata_ff <= {31'h0, clrcfg_ff};
                    sih_pkg::OFS_ASSIGN: prdata_ff <= {30'h0, assign_ff};
                    sih_pkg::OFS_STATE:  prdata_ff <= {24'h0, alarm_active, lock_ff,
                                                       base_ff, fif.clean};
                    sih_pkg::OFS_ISTAT:  prdata_ff <= {27'h0, istat_ff};
                    sih_pkg::OFS_IMASK:  prdata_ff <= {27'h0, imask_ff};
                    default:             prdata_ff <= '0;
                endcase
            end
        end
    end

    // Software-written configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_ff  <= sih_pkg::FORCE_RST;
            clrcfg_ff <= sih_pkg::CLRCFG_RST;
            assign_ff <= sih_pkg::sih_aux_type'(sih_pkg::ASSIGN_RST);
            imask_ff  <= sih_pkg::IMASK_RST;
        end else if (wr_done) begin
            if (paddr == sih_pkg::OFS_FORCE)  force_ff  <= pwdata[2:0];
            if (paddr == sih_pkg::OFS_CLRCFG) clrcfg_ff <= pwdata[0:0];  // RULE6
            if (paddr == sih_pkg::OFS_ASSIGN) assign_ff <= sih_pkg::sih_aux_type'(pwdata[1:0]);
            if (paddr == sih_pkg::OFS_IMASK)  imask_ff  <= pwdata[4:0];
        end
    end

    assign events = {base_ff != nxt_base,
                     fif.changed[sih_pkg::IN_REV] & !fif.clean[sih_pkg::IN_REV],
                     fif.changed[sih_pkg::IN_FWD] & !fif.clean[sih_pkg::IN_FWD],
                     fif.changed[sih_pkg::IN_CLR],
                     fif.changed[sih_pkg::IN_EN]};

    // Sticky events clear on a status read; a new event wins over the clear.
    // Only the bits latched for the reader are cleared, so an event that lands
    // in the setup cycle, after the read data was taken, is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_ff <= '0;
            irq_ff   <= 1'b0;
        end else begin
            if (rd_done && paddr == sih_pkg::OFS_ISTAT) begin
                istat_ff <= (istat_ff & ~prdata_ff[sih_pkg::EV_WIDTH-1:0]) | events;
            end else begin
                istat_ff <= istat_ff | events;
            end
            irq_ff <= |(istat_ff & imask_ff);
        end
    end

    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign base_enable = base_ff;
    assign ccw_allow   = ccw_ff;
    assign cw_allow    = cw_ff;
    assign servo_lock  = lock_ff;
    assign irq         = irq_ff;

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Accepted enable with no clear turns the base on next cycle.
    base_on_a:     assert property (fif.clean[0] && !eff_clr |=> base_enable) // RULE2
        else $error("Base not on with enable.");
    // Open enable without forcing shuts the base off.
    base_off_a:    assert property (!fif.clean[0] && !force_ff[0] |=> !base_enable) // RULE3
        else $error("Base on with enable open.");
    // Forced enable held two cycles without clear has the base on in the next cycle.
    force_en_a:    assert property (force_ff[0] && !eff_clr [*2] |=> base_enable) // RULE4
        else $error("Forced enable ignored.");
    // Clear without alarm and without keep shuts the base off.
    clr_off_a:     assert property (eff_clr && !alarm_active && !clrcfg_ff[0] // RULE5
                                    |=> !base_enable)
        else $error("Clear did not shut base off.");
    // Keep bit holds the base on through a clear.
    clr_keep_a:    assert property (eff_en && clrcfg_ff[0] |=> base_enable) // RULE6
        else $error("Base dropped with keep set.");
    // Open forward limit locks the servo and blocks CCW.
    fwd_stop_a:    assert property (!eff_fwd |=> servo_lock && !ccw_allow) // RULE8
        else $error("Forward limit did not stop.");
    // Forced limits allow both directions.
    lim_force_a:   assert property (force_ff[1] && force_ff[2] |=> ccw_allow && cw_allow) // RULE9
        else $error("Forced limits not honoured.");
    // Unassigned optional terminal cannot act as a clear.
    aux_gate_a:    assert property (assign_ff == sih_pkg::SIH_AUX_NONE && eff_en && // RULE10
                                    !fif.clean[1] |=> base_enable)
        else $error("Unassigned terminal acted.");
    // Reverse limit blocks only CW travel.
    rev_dir_a:     assert property (eff_fwd && !eff_rev |=> ccw_allow && !cw_allow) // RULE11
        else $error("Reverse limit gating wrong.");
    // An unmasked enable change raises the interrupt two cycles later.
    irq_a:         assert property (fif.changed[0] && imask_ff[0] ##1 imask_ff[0] |=> irq)
        else $error("Interrupt not raised.");

    base_cov_c:  cover property (!base_enable ##1 base_enable);
    lock_cov_c:  cover property (!servo_lock ##1 servo_lock);
    clr_cov_c:   cover property (eff_en && eff_clr && !alarm_active ##1 !base_enable);

endmodule : sih_top

`default_nettype wire
